// [rtl/scsr_pkg.sv]
// Constants, field layouts and carriers for the system control/status bank.
// Assumes a 12-bit byte address on a plain strobe bus with 32-bit data.
package scsr_pkg;

  localparam int ADDR_W = 12;
  localparam int CTRL_COUNT = 7;
  localparam int SYNC_STAGES = 2;

  localparam logic [ADDR_W-1:0] STATUS_OFFSET = 12'h14c;

  // Control register slots
  localparam logic [2:0] IDX_DDR_LP   = 3'h0;
  localparam logic [2:0] IDX_DISPLAY  = 3'h1;
  localparam logic [2:0] IDX_DMA_MODE = 3'h2;
  localparam logic [2:0] IDX_DMA_LO   = 3'h3;
  localparam logic [2:0] IDX_DMA_HI   = 3'h4;
  localparam logic [2:0] IDX_MAC_DLY  = 3'h5;
  localparam logic [2:0] IDX_MAC_CLK  = 3'h6;
  localparam logic [2:0] IDX_NONE     = 3'h7;

  localparam logic [ADDR_W-1:0] CTRL_OFFSET [CTRL_COUNT] =
    '{12'h148, 12'h150, 12'h15c, 12'h160, 12'h164, 12'h168, 12'h16c};
  // Implemented low-half bits; all others read zero
  localparam logic [15:0] CTRL_IMPL [CTRL_COUNT] =
    '{16'h0003, 16'h001f, 16'h0001, 16'hffff, 16'h003f, 16'hffff, 16'h7800};
  localparam logic [15:0] CTRL_RESET [CTRL_COUNT] =
    '{16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0010, 16'h0810, 16'h4000};

  localparam int MASK_LSB = 16;

  localparam int DDR_DENY_BIT       = 0;
  localparam int DDR_SELFREF_BIT    = 1;
  localparam int DISP_SRC_BIT       = 0;
  localparam int DISP_FMT_LSB       = 1;
  localparam int DISP_MSB_BIT       = 3;
  localparam int DISP_SHUTDOWN_BIT  = 4;
  localparam int DMA_DIRECT_BIT     = 0;
  localparam int DMA_HI_LSB         = 0;
  localparam int DMA_TYPE_LSB       = 4;
  localparam int DMA_LO_ADDR_LSB    = 12;
  localparam int MAC_TX_VAL_LSB     = 0;
  localparam int MAC_RX_VAL_LSB     = 7;
  localparam int MAC_TX_EN_BIT      = 14;
  localparam int MAC_RX_EN_BIT      = 15;
  localparam int RMII_REF_BIT       = 11;
  localparam int RGMII_CLK_LSB      = 12;
  localparam int RMII_MODE_BIT      = 14;

  localparam int ST_HEADSET   = 31;
  localparam int ST_IDLE_LSB  = 22;
  localparam int ST_ACK_LSB   = 14;
  localparam int ST_HOST_ID   = 13;
  localparam int ST_HOST_LS   = 11;
  localparam int ST_HOST_BSES = 10;
  localparam int ST_HOST_VBUS = 9;
  localparam int ST_OTG_ID    = 8;
  localparam int ST_OTG_LS    = 6;
  localparam int ST_OTG_BSES  = 5;
  localparam int ST_OTG_VBUS  = 4;

  localparam logic [1:0] DMA_TYPE_BURST = 2'h1;

  // Domain order: crypto, msched, system, gpu, video codec, video io, peri, core
  typedef struct packed {
    logic       headset_present;
    logic [7:0] idle_state;
    logic [7:0] idle_ack;
    logic [1:0] host_line_state;
    logic       host_b_session_ok;
    logic       host_bus_power_ok;
    logic       dual_role_id_state;
    logic [1:0] otg_line_state;
    logic       otg_b_session_ok;
    logic       otg_bus_power_ok;
    logic [3:0] pll_lock;
  } status_in_t;

  localparam int STATUS_IN_W = $bits(status_in_t);

  typedef struct packed {
    logic        ddr_selfref_req;
    logic        ddr_lp_deny;
    logic        dsi_shutdown;
    logic        lvds_msb_on_d7;
    logic [1:0]  lvds_format;
    logic        lvds_src_epaper;
    logic        dma_boot_direct;
    logic [31:0] dma_boot_addr;
    logic [1:0]  dma_req_type;
    logic        rx_delay_en;
    logic        tx_delay_en;
    logic [6:0]  rx_delay_value;
    logic [6:0]  tx_delay_value;
    logic        rmii_mode;
    logic [1:0]  rgmii_clk_sel;
    logic        rmii_ref_25m;
  } ctrl_out_t;

  function automatic logic [2:0] ctrl_index(input logic [ADDR_W-1:0] a);
    ctrl_index = IDX_NONE;
    for (int i = 0; i < CTRL_COUNT; i++)
    begin
      if (a == CTRL_OFFSET[i])
        ctrl_index = 3'(i);
    end
  endfunction

  function automatic logic [31:0] pack_status(input status_in_t s);
    pack_status = {s.headset_present, 1'b0, s.idle_state, s.idle_ack, 1'b0,
                   s.host_line_state, s.host_b_session_ok, s.host_bus_power_ok,
                   s.dual_role_id_state, s.otg_line_state, s.otg_b_session_ok,
                   s.otg_bus_power_ok, s.pll_lock};
  endfunction

endpackage

// [rtl/signal_sync.sv]
// Multi-bit level synchroniser for status inputs from other domains.
// Assumes each bit is a slow level; bits are not coherent with each other.
`timescale 1ns/1ns
module signal_sync #(
  parameter int WIDTH  = 30
) (
  input  wire logic             mclk,
  input  wire logic             rstn,
  input  wire logic [WIDTH-1:0] d,
  output logic      [WIDTH-1:0] q
);

  logic [WIDTH-1:0] meta;

  // First stage is read only by the second stage
  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      meta <= '0;
      q    <= '0;
    end
    else
    begin
      meta <= d;
      q    <= meta;
    end
  end

endmodule

// [rtl/masked_ctrl_reg.sv]
// One control register with a per-bit write mask in the upper half.
// Assumes wr_en is a one-cycle strobe already qualified by address.
`timescale 1ns/1ns
module masked_ctrl_reg #(
  parameter logic [15:0] IMPL  = 16'hffff,
  parameter logic [15:0] RESET = 16'h0000
) (
  input  wire logic        mclk,
  input  wire logic        rstn,
  input  wire logic        wr_en,
  input  wire logic [31:0] wdata,
  output logic      [15:0] q
);

  logic [15:0] lane_en;
  logic [15:0] next_q;

  always_comb
  begin
    lane_en = wdata[31:16] & IMPL;
    next_q  = (q & ~lane_en) | (wdata[15:0] & lane_en);
  end

  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
      q <= RESET & IMPL;
    else if (wr_en)
      q <= next_q;
  end

endmodule

// [rtl/system_control_status_regs.sv]
// System control and status register bank with write-masked controls.
// Assumes a single-cycle strobe master on mclk; status inputs may be async.
//
// Overview of operation
// - Upper half bits enable lower bit writes
// - Masked-off lower bits keep their value
// - DDR bit 1 drives self-refresh request
// - DDR bit 0 denies hardware low power
// - Status bit 31 shows headset present
// - Status 29:22 show eight domain idle states
// - Status 21:14 show eight idle acknowledges
// - Status bit 13 always reads zero
// - Line state fields encode SE1, K, J, SE0
// - Line state follows receiver levels
// - Bits 10 and 5 show B-session valid
// - Bits 9 and 4 show VBUS valid
// - Bit 8 shows dual-role ID pin
// - Bits 3:0 show four PLL locks
// - Display 2:1 selects LVDS output format
// - Display bit 0 selects e-paper source
// - DMA bit 0 selects direct boot
// - DMA boot address from two fields
// - DMA 5:4 request type, resets burst
// - MAC delay enables and values, reset 0x10
// - MAC clock select and RMII mode
// - MAC bit 11 selects RMII reference
`timescale 1ns/1ns
module system_control_status_regs (
  input  wire logic                         mclk,
  input  wire logic                         rstn,
  input  wire logic [scsr_pkg::ADDR_W-1:0]  addr,
  input  wire logic [31:0]                  wdata,
  input  wire logic                         wr,
  input  wire logic                         rd,
  output logic      [31:0]                  rdata,
  input  wire scsr_pkg::status_in_t         status_in,
  output scsr_pkg::ctrl_out_t               ctrl_out
);

  logic [15:0]                    ctrl_q [scsr_pkg::CTRL_COUNT];
  logic [2:0]                     sel;
  logic [scsr_pkg::STATUS_IN_W-1:0] status_raw;
  scsr_pkg::status_in_t           status_sync;
  logic [31:0]                    status_word;
  logic [31:0]                    next_rdata;

  // Address decode shared by reads and writes
  assign sel = scsr_pkg::ctrl_index(addr);

  genvar g;
  generate
    for (g = 0; g < scsr_pkg::CTRL_COUNT; g++)
    begin : g_ctrl
      masked_ctrl_reg #(
        .IMPL  (scsr_pkg::CTRL_IMPL[g]),
        .RESET (scsr_pkg::CTRL_RESET[g])
      ) u_reg (
        .mclk  (mclk),
        .rstn  (rstn),
        .wr_en (wr && (sel == 3'(g))),
        .wdata (wdata),
        .q     (ctrl_q[g])
      );
    end
  endgenerate

  // Status comes from other blocks and clocks, so every bit is resynchronised.
  // Line state is therefore two cycles behind the receivers, not combinational.
  assign status_raw = status_in;

  signal_sync #(
    .WIDTH (scsr_pkg::STATUS_IN_W)
  ) u_status_sync (
    .mclk  (mclk),
    .rstn  (rstn),
    .d     (status_raw),
    .q     (status_sync)
  );

  assign status_word = scsr_pkg::pack_status(status_sync);

  // Read data stand for exactly one cycle after the strobe
  always_comb
  begin
    next_rdata = 32'h0000_0000;
    if (rd)
    begin
      if (addr == scsr_pkg::STATUS_OFFSET)
        next_rdata = status_word;
      else if (sel != scsr_pkg::IDX_NONE)
        next_rdata = {16'h0000, ctrl_q[sel]};
    end
  end

  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
      rdata <= 32'h0000_0000;
    else
      rdata <= next_rdata;
  end

  // Outputs are plain register bits, no logic after the flops
  always_comb
  begin
    ctrl_out.ddr_selfref_req =
      ctrl_q[scsr_pkg::IDX_DDR_LP][scsr_pkg::DDR_SELFREF_BIT];
    ctrl_out.ddr_lp_deny     =
      ctrl_q[scsr_pkg::IDX_DDR_LP][scsr_pkg::DDR_DENY_BIT];
    ctrl_out.dsi_shutdown    =
      ctrl_q[scsr_pkg::IDX_DISPLAY][scsr_pkg::DISP_SHUTDOWN_BIT];
    ctrl_out.lvds_msb_on_d7  =
      ctrl_q[scsr_pkg::IDX_DISPLAY][scsr_pkg::DISP_MSB_BIT];
    ctrl_out.lvds_format     =
      ctrl_q[scsr_pkg::IDX_DISPLAY][scsr_pkg::DISP_FMT_LSB +: 2];
    ctrl_out.lvds_src_epaper =
      ctrl_q[scsr_pkg::IDX_DISPLAY][scsr_pkg::DISP_SRC_BIT];
    ctrl_out.dma_boot_direct =
      ctrl_q[scsr_pkg::IDX_DMA_MODE][scsr_pkg::DMA_DIRECT_BIT];
    // Low twelve address bits are zero: boot code is 4 KiB aligned
    ctrl_out.dma_boot_addr   = {ctrl_q[scsr_pkg::IDX_DMA_HI][scsr_pkg::DMA_HI_LSB +: 4],
                                ctrl_q[scsr_pkg::IDX_DMA_LO],
                                12'h000};
    ctrl_out.dma_req_type    =
      ctrl_q[scsr_pkg::IDX_DMA_HI][scsr_pkg::DMA_TYPE_LSB +: 2];
    ctrl_out.rx_delay_en     =
      ctrl_q[scsr_pkg::IDX_MAC_DLY][scsr_pkg::MAC_RX_EN_BIT];
    ctrl_out.tx_delay_en     =
      ctrl_q[scsr_pkg::IDX_MAC_DLY][scsr_pkg::MAC_TX_EN_BIT];
    ctrl_out.rx_delay_value  =
      ctrl_q[scsr_pkg::IDX_MAC_DLY][scsr_pkg::MAC_RX_VAL_LSB +: 7];
    ctrl_out.tx_delay_value  =
      ctrl_q[scsr_pkg::IDX_MAC_DLY][scsr_pkg::MAC_TX_VAL_LSB +: 7];
    ctrl_out.rmii_mode       =
      ctrl_q[scsr_pkg::IDX_MAC_CLK][scsr_pkg::RMII_MODE_BIT];
    ctrl_out.rgmii_clk_sel   =
      ctrl_q[scsr_pkg::IDX_MAC_CLK][scsr_pkg::RGMII_CLK_LSB +: 2];
    ctrl_out.rmii_ref_25m    =
      ctrl_q[scsr_pkg::IDX_MAC_CLK][scsr_pkg::RMII_REF_BIT];
  end

  // Checks against the documented behaviour

  logic [2:0] rst_age;

  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
      rst_age <= 3'h0;
    else if (rst_age != 3'h7)
      rst_age <= rst_age + 3'h1;
  end

  a_mask_write_takes: assert property (
    @(posedge mclk) disable iff (!rstn)
    (wr && addr == scsr_pkg::CTRL_OFFSET[1] && wdata[scsr_pkg::MASK_LSB])
    |=> (ctrl_out.lvds_src_epaper == $past(wdata[0])))
    else $error("masked display write did not take");

  a_mask_block_hold: assert property (
    @(posedge mclk) disable iff (!rstn)
    (wr && addr == scsr_pkg::CTRL_OFFSET[6] && !wdata[30])
    |=> $stable(ctrl_out.rmii_mode))
    else $error("unmasked rmii bit changed");

  a_selfref_follow: assert property (
    @(posedge mclk) disable iff (!rstn)
    (wr && addr == scsr_pkg::CTRL_OFFSET[0] && wdata[17])
    |=> ctrl_out.ddr_selfref_req == $past(wdata[1])
        ##1 (ctrl_out.ddr_selfref_req == $past(ctrl_out.ddr_selfref_req)
             || $past(wr)))
    else $error("self-refresh request not following write");

  a_deny_reset_low: assert property (
    @(posedge mclk) disable iff (!rstn)
    (rst_age == 3'h0) |-> (!ctrl_out.ddr_lp_deny && !ctrl_out.ddr_selfref_req))
    else $error("ddr low power bits not zero after reset");

  a_status_headset: assert property (
    @(posedge mclk) disable iff (!rstn)
    (rd && addr == scsr_pkg::STATUS_OFFSET)
    |=> rdata[scsr_pkg::ST_HEADSET] == $past(status_sync.headset_present))
    else $error("headset flag misread");

  a_status_idle_map: assert property (
    @(posedge mclk) disable iff (!rstn)
    (rd && addr == scsr_pkg::STATUS_OFFSET)
    |=> (rdata[scsr_pkg::ST_IDLE_LSB +: 8] == $past(status_sync.idle_state))
        && (rdata[scsr_pkg::ST_ACK_LSB +: 8] == $past(status_sync.idle_ack)))
    else $error("idle state or acknowledge misplaced");

  a_status_host_id: assert property (
    @(posedge mclk) disable iff (!rstn)
    (rd && addr == scsr_pkg::STATUS_OFFSET)
    |=> (!rdata[scsr_pkg::ST_HOST_ID] && !rdata[30]))
    else $error("fixed-zero status bits read as one");

  a_status_line: assert property (
    @(posedge mclk) disable iff (!rstn)
    (rd && addr == scsr_pkg::STATUS_OFFSET && rst_age == 3'h7)
    |=> rdata[scsr_pkg::ST_HOST_LS +: 2] == $past(status_in.host_line_state, 3))
    else $error("host line state not following receivers");

  a_status_usb: assert property (
    @(posedge mclk) disable iff (!rstn)
    (rd && addr == scsr_pkg::STATUS_OFFSET)
    |=> (rdata[scsr_pkg::ST_HOST_BSES] == $past(status_sync.host_b_session_ok))
        && (rdata[scsr_pkg::ST_OTG_VBUS] == $past(status_sync.otg_bus_power_ok))
        && (rdata[scsr_pkg::ST_OTG_ID] == $past(status_sync.dual_role_id_state)))
    else $error("usb session flags misplaced");

  a_status_pll: assert property (
    @(posedge mclk) disable iff (!rstn)
    (rd && addr == scsr_pkg::STATUS_OFFSET)
    |=> rdata[3:0] == $past(status_sync.pll_lock))
    else $error("pll lock flags misread");

  a_display_fields: assert property (
    @(posedge mclk) disable iff (!rstn)
    (wr && addr == scsr_pkg::CTRL_OFFSET[1] && wdata[20:17] == 4'hf)
    |=> (ctrl_out.dsi_shutdown == $past(wdata[4]))
        && (ctrl_out.lvds_msb_on_d7 == $past(wdata[3]))
        && (ctrl_out.lvds_format == $past(wdata[2:1])))
    else $error("display fields not written");

  a_dma_direct: assert property (
    @(posedge mclk) disable iff (!rstn)
    (wr && addr == scsr_pkg::CTRL_OFFSET[2] && wdata[16])
    |=> ctrl_out.dma_boot_direct == $past(wdata[0]))
    else $error("dma boot mode not written");

  a_boot_addr_form: assert property (
    @(posedge mclk) disable iff (!rstn)
    (wr && addr == scsr_pkg::CTRL_OFFSET[3] && wdata[31:16] == 16'hffff)
    |=> (ctrl_out.dma_boot_addr[27:12] == $past(wdata[15:0]))
        && (ctrl_out.dma_boot_addr[11:0] == 12'h000)
        && $stable(ctrl_out.dma_boot_addr[31:28]))
    else $error("boot address low field misplaced");

  a_req_type_reset: assert property (
    @(posedge mclk) disable iff (!rstn)
    (rst_age == 3'h0)
    |-> (ctrl_out.dma_req_type == scsr_pkg::DMA_TYPE_BURST)
        && (ctrl_out.rx_delay_value == 7'h10) && (ctrl_out.tx_delay_value == 7'h10)
        && ctrl_out.rmii_mode && (ctrl_out.rgmii_clk_sel == 2'h0))
    else $error("reset values wrong");

  a_mac_clock_write: assert property (
    @(posedge mclk) disable iff (!rstn)
    (wr && addr == scsr_pkg::CTRL_OFFSET[6] && wdata[29:27] == 3'h7)
    |=> (ctrl_out.rgmii_clk_sel == $past(wdata[13:12]))
        && (ctrl_out.rmii_ref_25m == $past(wdata[11])))
    else $error("mac clock fields not written");

  a_mask_reads_zero: assert property (
    @(posedge mclk) disable iff (!rstn)
    (rd && addr != scsr_pkg::STATUS_OFFSET) |=> rdata[31:16] == 16'h0000)
    else $error("mask half read back nonzero");

  a_status_write_nop: assert property (
    @(posedge mclk) disable iff (!rstn)
    (wr && addr == scsr_pkg::STATUS_OFFSET) |=> $stable(ctrl_out))
    else $error("status write changed a control");

  a_rdata_one_cycle: assert property (
    @(posedge mclk) disable iff (!rstn)
    !rd |=> rdata == 32'h0000_0000)
    else $error("read data outside its cycle");

  a_deny_write: assert property (
    @(posedge mclk) disable iff (!rstn)
    (wr && addr == scsr_pkg::CTRL_OFFSET[0] && wdata[16])
    |=> ctrl_out.ddr_lp_deny == $past(wdata[0]))
    else $error("low power deny bit not written");

  a_src_mask_hold: assert property (
    @(posedge mclk) disable iff (!rstn)
    (wr && addr == scsr_pkg::CTRL_OFFSET[1] && !wdata[16])
    |=> $stable(ctrl_out.lvds_src_epaper))
    else $error("unmasked display source bit changed");

  a_delay_write: assert property (
    @(posedge mclk) disable iff (!rstn)
    (wr && addr == scsr_pkg::CTRL_OFFSET[5] && wdata[31:16] == 16'hffff)
    |=> (ctrl_out.rx_delay_en == $past(wdata[15]))
        && (ctrl_out.tx_delay_en == $past(wdata[14]))
        && (ctrl_out.rx_delay_value == $past(wdata[13:7]))
        && (ctrl_out.tx_delay_value == $past(wdata[6:0])))
    else $error("mac delay fields not written");

  a_req_type_write: assert property (
    @(posedge mclk) disable iff (!rstn)
    (wr && addr == scsr_pkg::CTRL_OFFSET[4] && wdata[21:20] == 2'h3)
    |=> ctrl_out.dma_req_type == $past(wdata[5:4]))
    else $error("dma request type not written");

  a_boot_addr_high: assert property (
    @(posedge mclk) disable iff (!rstn)
    (wr && addr == scsr_pkg::CTRL_OFFSET[4] && wdata[19:16] == 4'hf)
    |=> (ctrl_out.dma_boot_addr[31:28] == $past(wdata[3:0]))
        && $stable(ctrl_out.dma_boot_addr[27:0]))
    else $error("boot address high field misplaced");

  a_rmii_mode_write: assert property (
    @(posedge mclk) disable iff (!rstn)
    (wr && addr == scsr_pkg::CTRL_OFFSET[6] && wdata[30])
    |=> ctrl_out.rmii_mode == $past(wdata[14]))
    else $error("rmii mode bit not written");

  a_status_usb_rest: assert property (
    @(posedge mclk) disable iff (!rstn)
    (rd && addr == scsr_pkg::STATUS_OFFSET)
    |=> (rdata[scsr_pkg::ST_HOST_VBUS] == $past(status_sync.host_bus_power_ok))
        && (rdata[scsr_pkg::ST_OTG_BSES] == $past(status_sync.otg_b_session_ok)))
    else $error("usb power flags misplaced");

  a_status_otg_line: assert property (
    @(posedge mclk) disable iff (!rstn)
    (rd && addr == scsr_pkg::STATUS_OFFSET && rst_age == 3'h7)
    |=> rdata[scsr_pkg::ST_OTG_LS +: 2] == $past(status_in.otg_line_state, 3))
    else $error("otg line state not following receivers");

  a_unmapped_read_zero: assert property (
    @(posedge mclk) disable iff (!rstn)
    (rd && addr != scsr_pkg::STATUS_OFFSET && sel == scsr_pkg::IDX_NONE)
    |=> rdata == 32'h0000_0000)
    else $error("unmapped read returned data");

  a_fixed_reset_zero: assert property (
    @(posedge mclk) disable iff (!rstn)
    (rst_age == 3'h0)
    |-> !ctrl_out.dsi_shutdown && !ctrl_out.lvds_msb_on_d7
        && (ctrl_out.lvds_format == 2'h0) && !ctrl_out.lvds_src_epaper
        && !ctrl_out.dma_boot_direct && (ctrl_out.dma_boot_addr == 32'h0000_0000)
        && !ctrl_out.rx_delay_en && !ctrl_out.tx_delay_en && !ctrl_out.rmii_ref_25m)
    else $error("zero-reset controls not zero after reset");

  a_delay_mask_hold: assert property (
    @(posedge mclk) disable iff (!rstn)
    (wr && addr == scsr_pkg::CTRL_OFFSET[5] && !wdata[31])
    |=> $stable(ctrl_out.rx_delay_en))
    else $error("unmasked rx delay enable changed");

endmodule

// [verification/status_source.sv]
// Far-side model: neighbouring blocks that drive the status levels.
// Assumes the bench hands it a 30-bit level vector in status_in_t order.
`timescale 1ns/1ns
module status_source (
  input  wire logic            mclk,
  input  wire logic [29:0]     level,
  output scsr_pkg::status_in_t status_in
);
  // Levels move just after an edge, as a flop in another block would
  always @(posedge mclk)
    status_in <= scsr_pkg::status_in_t'(level);
endmodule

// [verification/test_system_control_status_regs.sv]
// Self-checking bench for the control/status bank, with a reference model.
// Assumes the status path lags by the far-side flop plus two sync stages.
`timescale 1ns/1ns
module test_system_control_status_regs;
  logic                        mclk = 1'b0;
  logic                        rstn = 1'b0;
  logic [scsr_pkg::ADDR_W-1:0] addr = '0;
  logic [31:0]                 wdata = '0;
  logic                        wr = 1'b0;
  logic                        rd = 1'b0;
  logic [31:0]                 rdata;
  logic [29:0]                 level = '0;
  scsr_pkg::status_in_t        status_in;
  scsr_pkg::ctrl_out_t         ctrl_out;
  logic [15:0]                 m [7];
  logic [11:0]                 offs [$] = '{12'h148, 12'h150, 12'h15c, 12'h160, 12'h164,
                                            12'h168, 12'h16c, 12'h14c, 12'h154};
  int                          err_total = 0;
  int                          checks_done = 0;

  always #25 mclk = ~mclk;

  status_source status_source_inst (
    .mclk      (mclk),
    .level     (level),
    .status_in (status_in)
  );

  system_control_status_regs system_control_status_regs_inst (
    .mclk      (mclk),
    .rstn      (rstn),
    .addr      (addr),
    .wdata     (wdata),
    .wr        (wr),
    .rd        (rd),
    .rdata     (rdata),
    .status_in (status_in),
    .ctrl_out  (ctrl_out)
  );

  task automatic tally_and_finish();
    $display("checks_done=%0d err_total=%0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      err_total++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic model_reset();
    m = '{16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0010, 16'h0810, 16'h4000};
  endtask

  function automatic scsr_pkg::ctrl_out_t exp_ctrl();
    scsr_pkg::ctrl_out_t e;
    e.ddr_selfref_req = m[0][1];
    e.ddr_lp_deny = m[0][0];
    e.dsi_shutdown = m[1][4];
    e.lvds_msb_on_d7 = m[1][3];
    e.lvds_format = m[1][2:1];
    e.lvds_src_epaper = m[1][0];
    e.dma_boot_direct = m[2][0];
    e.dma_boot_addr = {m[4][3:0], m[3], 12'h000};
    e.dma_req_type = m[4][5:4];
    e.rx_delay_en = m[5][15];
    e.tx_delay_en = m[5][14];
    e.rx_delay_value = m[5][13:7];
    e.tx_delay_value = m[5][6:0];
    e.rmii_mode = m[6][14];
    e.rgmii_clk_sel = m[6][13:12];
    e.rmii_ref_25m = m[6][11];
    return e;
  endfunction

  function automatic logic [31:0] exp_rd(input logic [11:0] a);
    exp_rd = '0;
    for (int i = 0; i < 7; i++)
      if (a == offs[i])
        exp_rd = {16'h0000, m[i]};
    // Gaps at 30 and 13 always read zero
    if (a == 12'h14c)
      exp_rd = {level[29], 1'b0, level[28:13], 1'b0, level[12:0]};
  endfunction

  task automatic bus_wr(input logic [11:0] a, input logic [31:0] d);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge mclk);
    wr <= 1'b0;
    for (int i = 0; i < 7; i++)
      if (a == offs[i])
        m[i] = (m[i] & ~d[31:16]) | (d[15:0] & d[31:16] & scsr_pkg::CTRL_IMPL[i]);
  endtask

  // Also checks ctrl_out, and that rdata falls back to zero a cycle later
  task automatic bus_rd(input logic [11:0] a);
    logic [31:0] e;
    e = exp_rd(a);
    addr <= a;
    rd <= 1'b1;
    @(posedge mclk);
    rd <= 1'b0;
    #1;
    chk(rdata, e);
    chk(ctrl_out, exp_ctrl());
    @(posedge mclk);
    #1;
    chk(rdata, '0);
    // Hand back on an edge so the next request starts there
    @(posedge mclk);
  endtask

  task automatic settle_status(input logic [29:0] v);
    level <= v;
    repeat (4) @(posedge mclk);
  endtask

  initial
  begin
    repeat (20000) @(posedge mclk);
    err_total++;
    tally_and_finish();
  end

  initial
  begin
    void'($urandom(31));
    model_reset();
    repeat (8) @(posedge mclk);
    rstn <= 1'b1;
    @(posedge mclk);
    foreach (offs[i])
      bus_rd(offs[i]);
    // Data with an empty mask must leave every control as it was
    foreach (offs[i])
    begin
      bus_wr(offs[i], 32'h0000_ffff);
      bus_rd(offs[i]);
    end
    // Full masks with random data reach every field at once
    foreach (offs[i])
    begin
      bus_wr(offs[i], {16'hffff, 16'($urandom)});
      bus_rd(offs[i]);
    end
    for (int c = 0; c < 4; c++)
    begin
      bus_wr(12'h150, 32'h0006_0000 | 32'(c << 1));
      bus_rd(12'h150);
      bus_wr(12'h164, 32'h0030_0000 | 32'(c << 4));
      bus_rd(12'h164);
      bus_wr(12'h16c, 32'h3000_0000 | 32'(c << 12));
      bus_rd(12'h16c);
      settle_status(30'((c << 11) | (c << 6)));
      bus_rd(12'h14c);
    end
    // Random masks and data, including the status and an unmapped place
    for (int n = 0; n < 60; n++)
    begin
      bus_wr(offs[$urandom_range(8)], $urandom);
      bus_rd(offs[$urandom_range(8)]);
      settle_status(30'($urandom));
      bus_rd(12'h14c);
    end
    // Second reset in mid-run brings every control back
    rstn <= 1'b0;
    repeat (2) @(posedge mclk);
    model_reset();
    level <= '0;
    rstn <= 1'b1;
    repeat (3) @(posedge mclk);
    foreach (offs[i])
      bus_rd(offs[i]);
    tally_and_finish();
  end
endmodule
